// File: cssp_map.svh
// Named constants for the converter start-up, soft-start and power-good block.
// Assumes inclusion by bare name; definitions only.
`ifndef CSSP_MAP_SVH
`define CSSP_MAP_SVH

// ----------------------------------------------------------------------------
// Clock and timebase
// ----------------------------------------------------------------------------
`define CSSP_CLK_PERIOD_NS  5
`define CSSP_US_NS          1000
`define CSSP_MS_US          1000
`define CSSP_CYC_PER_US     (`CSSP_US_NS / `CSSP_CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Start-up timing in milliseconds
// ----------------------------------------------------------------------------
`define CSSP_INIT_MS        10
`define CSSP_MIN_DELAY_MS   8'h02
`define CSSP_ACOMP_DELAY_MS 8'h05

// ----------------------------------------------------------------------------
// Strap three-state and resistor delay and ramp values in milliseconds, last resistor code
// ----------------------------------------------------------------------------
`define CSSP_SS_LOW_MS      8'h02
`define CSSP_SS_OPEN_MS     8'h05
`define CSSP_SS_HIGH_MS     8'h0A
`define CSSP_SS_R_5MS       8'h05
`define CSSP_SS_R_10MS      8'h0A
`define CSSP_SS_R_20MS      8'h14
`define CSSP_SS_R_2MS       8'h02
`define CSSP_SS_CODE_LAST   5'h1D

// ----------------------------------------------------------------------------
// Ramp level and power-good defaults
// ----------------------------------------------------------------------------
`define CSSP_LEVEL_MAX      8'hFF
`define CSSP_PCT_FULL       8'h64
`define CSSP_GOOD_HI_PCT    8'h0F
`define CSSP_GOOD_LO_PCT    8'h0A
`define CSSP_GOOD_DELAY_MS  8'h01

`endif

// File: cssp_pkg.sv
// Types shared by the start-up sequencer and its strap decoder.
// Assumes cssp_map.svh for all numeric constants.
package cssp_pkg;

   // -------------------------------------------------------------------------
   // Sequencer states
   // -------------------------------------------------------------------------
   typedef enum logic [2:0] {
      S_MEMCHK,
      S_STRAP,
      S_READY,
      S_DELAY,
      S_RAMP,
      S_ON
   } cssp_state_t;

   // -------------------------------------------------------------------------
   // Soft-start strap sensing
   // -------------------------------------------------------------------------
   typedef enum logic [1:0] {
      STRAP_LOW,
      STRAP_OPEN,
      STRAP_HIGH,
      STRAP_RES
   } cssp_strap_t;

endpackage

// File: cssp_timebase.sv
// Microsecond and millisecond tick generator.
// Assumes one clock; clear_i restarts the tick phase.
`timescale 1ns/100ps
`default_nettype none

module cssp_timebase #(
   parameter int CYC_PER_US = 200,
   parameter int US_PER_MS  = 1000
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Control
   input  wire logic clear_i,
   // Ticks
   output logic      us_tick_o,
   output logic      ms_tick_o
);

   logic [15:0] cyc_reg;
   logic [15:0] us_reg;
   wire         us_end = (cyc_reg == 16'(CYC_PER_US - 1));
   wire         ms_end = us_end && (us_reg == 16'(US_PER_MS - 1));

   if (CYC_PER_US < 1 || CYC_PER_US > 65535 || US_PER_MS < 1 || US_PER_MS > 65535) begin
      $error("cssp_timebase: unsupported tick parameters");
   end

   // ------------------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cyc_reg   <= 16'h0000;
         us_reg    <= 16'h0000;
         us_tick_o <= 1'b0;
         ms_tick_o <= 1'b0;
      end else if (clear_i) begin
         cyc_reg   <= 16'h0000;
         us_reg    <= 16'h0000;
         us_tick_o <= 1'b0;
         ms_tick_o <= 1'b0;
      end else begin
         cyc_reg   <= us_end ? 16'h0000 : cyc_reg + 16'h0001;
         us_reg    <= ms_end ? 16'h0000 : (us_end ? us_reg + 16'h0001 : us_reg);
         us_tick_o <= us_end;
         ms_tick_o <= ms_end;
      end
   end

endmodule

`default_nettype wire

// File: cssp_ss_decode.sv
// Soft-start strap decoder: three-state level or resistor code to delay and ramp.
// Assumes the resistor code is 0 for the lowest resistor, one step per table row.
`timescale 1ns/100ps
`default_nettype none
`include "cssp_map.svh"

module cssp_ss_decode
   import cssp_pkg::*;
(
   // Strap sense
   input  wire logic [1:0] strap_i,
   input  wire logic [4:0] code_i,
   // Decoded times
   output logic      [7:0] delay_ms_o,
   output logic      [7:0] ramp_ms_o
);

   // ------------------------------------------------------------------------
   // Resistor lookup
   // ------------------------------------------------------------------------
   function automatic logic [7:0] res_delay(input logic [4:0] c);
      case (c % 5'h03)
         5'h00:   res_delay = `CSSP_SS_R_5MS;
         5'h01:   res_delay = `CSSP_SS_R_10MS;
         default: res_delay = `CSSP_SS_R_20MS;
      endcase
   endfunction

   function automatic logic [7:0] res_ramp(input logic [4:0] c);
      case (c / 5'h03)
         5'h00, 5'h03, 5'h07: res_ramp = `CSSP_SS_R_5MS;
         5'h01, 5'h04, 5'h08: res_ramp = `CSSP_SS_R_10MS;
         5'h02, 5'h06:        res_ramp = `CSSP_SS_R_2MS;
         default:             res_ramp = `CSSP_SS_R_20MS;
      endcase
   endfunction

   wire [4:0] code_w = (code_i > `CSSP_SS_CODE_LAST) ? `CSSP_SS_CODE_LAST : code_i;
   wire [7:0] lvl_w  = (strap_i == 2'(STRAP_LOW))  ? `CSSP_SS_LOW_MS  :
                       (strap_i == 2'(STRAP_OPEN)) ? `CSSP_SS_OPEN_MS : `CSSP_SS_HIGH_MS;
   wire       res_w  = (strap_i == 2'(STRAP_RES));

   assign delay_ms_o = res_w ? res_delay(code_w) : lvl_w; // R11 R12
   assign ramp_ms_o  = res_w ? res_ramp(code_w)  : lvl_w; // R11 R12

endmodule

`default_nettype wire

// File: cssp_sequencer.sv
// Start-up sequencer with soft-start delay, monotonic ramp and power-good.
// Assumes synchronous inputs and management-bus fields presented as plain ports.
//
// Overview of operation
// R01 - After power-up spend about 5 to 10 ms checking memory, load user values.
// R02 - After the memory check sample every strap and load its values.
// R03 - Accept bus commands and enable only after memory and strap loading.
// R04 - Wait at least 2 ms after enable; shorter delays become 2 ms.
// R05 - Delays over 2 ms are waited out in full before ramping.
// R06 - After the delay, ramp the output over the configured ramp time.
// R07 - Enable held from power-up still waits for the full initialisation.
// R08 - Delay interval runs from enable assertion until the delay elapses.
// R09 - A precise-timing bit reduces variation of the delay.
// R10 - Output ramp is monotonic, slope set by the soft-start settings.
// R11 - Strap low, open, high select 2, 5, 10 ms delay and ramp.
// R12 - Resistor codes map through a table; delays cycle 5, 10, 20 ms.
// R13 - Strap measured only at start-up or restore, later changes ignored.
// R14 - Zero delay starts the ramp after about 2 ms of initialisation.
// R15 - Zero ramp time drives the output straight to target.
// R16 - Host should program ramps longer than 500 us against inrush.
// R17 - With automatic compensation on, turn-on delay is at least 5 ms.
// R18 - Power-good only inside the tolerance window and with no fault.
// R19 - Default window +15 / -10 percent, both limits host-programmable.
// R20 - Power-good delayed by a programmable interval, default 1 ms.
// R21 - Host stabilises any sync clock before asserting enable.
// R22 - Enable and bus traffic ignored during memory check and strap sampling.
// R23 - A restore command reruns the memory check as at power-up.
// R24 - Power-good stays low while disabled and until the ramp finishes.
// R25 - All intervals counted on an internal timebase of 1 ms or finer.
`timescale 1ns/100ps
`default_nettype none
`include "cssp_map.svh"

module cssp_sequencer
   import cssp_pkg::*;
#(
   parameter int CYC_PER_US = `CSSP_CYC_PER_US,
   parameter int US_PER_MS  = `CSSP_MS_US,
   parameter int INIT_MS    = `CSSP_INIT_MS
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   // Enable and compensation
   input  wire logic       enable_i,
   input  wire logic       autocomp_en_i,
   // Stored configuration
   input  wire logic       nvm_user_valid_i,
   input  wire logic [7:0] nvm_delay_ms_i,
   input  wire logic [7:0] nvm_ramp_ms_i,
   // Soft-start strap
   input  wire logic [1:0] ss_strap_i,
   input  wire logic [4:0] ss_res_code_i,
   // Management bus fields
   input  wire logic       bus_write_i,
   input  wire logic [7:0] bus_delay_ms_i,
   input  wire logic [7:0] bus_ramp_ms_i,
   input  wire logic [7:0] bus_good_hi_pct_i,
   input  wire logic [7:0] bus_good_lo_pct_i,
   input  wire logic [7:0] bus_good_delay_ms_i,
   input  wire logic       bus_precise_i,
   input  wire logic       bus_restore_i,
   // Output sense and faults
   input  wire logic [9:0] vout_sense_i,
   input  wire logic       fault_i,
   // Status and output
   output logic            ready_o,
   output logic            delay_active_o,
   output logic            ramp_done_o,
   output logic      [7:0] ramp_level_o,
   output logic            power_good_output_o
);

   if (INIT_MS < 1 || INIT_MS > 255 || US_PER_MS < 255 || US_PER_MS > 1027) begin
      $error("cssp_sequencer: unsupported timing parameters");
   end

   // ------------------------------------------------------------------------
   // Reset synchroniser
   // ------------------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire rst_n = rst_sync_reg;

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   function automatic logic [7:0] eff_delay(input logic [7:0] d, input logic ac);
      logic [7:0] m;
      m = ac ? `CSSP_ACOMP_DELAY_MS : `CSSP_MIN_DELAY_MS;
      eff_delay = (d < m) ? m : d;
   endfunction

   function automatic logic in_window(input logic [9:0] v, input logic [7:0] hi,
                                      input logic [7:0] lo);
      logic [19:0] meas;
      logic [19:0] upper;
      logic [19:0] lower;
      logic [7:0]  lo_c;
      lo_c  = (lo > `CSSP_PCT_FULL) ? `CSSP_PCT_FULL : lo;
      meas  = 20'(v) * 20'(`CSSP_PCT_FULL);
      upper = 20'(`CSSP_LEVEL_MAX) * (20'(`CSSP_PCT_FULL) + 20'(hi));
      lower = 20'(`CSSP_LEVEL_MAX) * (20'(`CSSP_PCT_FULL) - 20'(lo_c));
      in_window = (meas <= upper) && (meas >= lower);
   endfunction

   // ------------------------------------------------------------------------
   // State and configuration registers
   // ------------------------------------------------------------------------
   cssp_state_t state_reg;
   cssp_state_t state_next;
   logic [7:0]  ms_cnt_reg;
   logic [7:0]  delay_ms_reg;
   logic [7:0]  ramp_ms_reg;
   logic [7:0]  good_hi_reg;
   logic [7:0]  good_lo_reg;
   logic [7:0]  good_dly_reg;
   logic        precise_reg;
   logic [17:0] err_reg;
   logic [7:0]  good_cnt_reg;
   logic        us_tick;
   logic        ms_tick;
   logic [7:0]  strap_delay;
   logic [7:0]  strap_ramp;

   wire ready_w   = (state_reg != S_MEMCHK) && (state_reg != S_STRAP); // R03 R22
   wire bus_take  = ready_w && bus_write_i; // R22
   wire restore_w = ready_w && bus_restore_i; // R23
   wire [7:0] eff_dly  = eff_delay(delay_ms_reg, autocomp_en_i); // R04 R14 R17
   wire init_done = (ms_cnt_reg >= 8'(INIT_MS)); // R01 R07
   wire dly_done  = (ms_cnt_reg >= eff_dly); // R05 R08
   wire [17:0] ramp_us  = 18'(ramp_ms_reg) * 18'(US_PER_MS);
   wire [17:0] err_sum  = err_reg + 18'(`CSSP_LEVEL_MAX);
   wire        step_w   = us_tick && (err_sum >= ramp_us); // R06 R10
   wire        enter_mc = (state_reg != S_MEMCHK) && (state_next == S_MEMCHK);
   wire        enter_dl = (state_reg == S_READY) && (state_next == S_DELAY);
   wire        enter_rp = (state_reg == S_DELAY) && (state_next == S_RAMP);
   wire        tb_clear = enter_mc || (enter_dl && precise_reg); // R09
   wire        good_cond = (state_reg == S_ON) && enable_i && !fault_i
                          && in_window(vout_sense_i, good_hi_reg, good_lo_reg); // R18 R24

   cssp_timebase #(
      .CYC_PER_US (CYC_PER_US),
      .US_PER_MS  (US_PER_MS)
   ) u_timebase (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n),
      .clear_i    (tb_clear),
      .us_tick_o  (us_tick),
      .ms_tick_o  (ms_tick)
   ); // R25

   cssp_ss_decode u_ss_decode (
      .strap_i    (ss_strap_i),
      .code_i     (ss_res_code_i),
      .delay_ms_o (strap_delay),
      .ramp_ms_o  (strap_ramp)
   );

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         S_MEMCHK: if (init_done) begin // R01 R07 R22
            state_next = S_STRAP;
         end
         S_STRAP:  state_next = S_READY; // R02
         S_READY:  if (restore_w) begin
            state_next = S_MEMCHK;
         end else if (enable_i) begin // R03 R08
            state_next = S_DELAY;
         end
         S_DELAY:  if (restore_w) begin
            state_next = S_MEMCHK;
         end else if (!enable_i) begin
            state_next = S_READY;
         end else if (dly_done) begin // R04 R05
            state_next = S_RAMP;
         end
         S_RAMP:   if (restore_w) begin
            state_next = S_MEMCHK;
         end else if (!enable_i) begin
            state_next = S_READY;
         end else if (ramp_level_o == `CSSP_LEVEL_MAX) begin
            state_next = S_ON;
         end
         S_ON:     if (restore_w) begin
            state_next = S_MEMCHK; // R23
         end else if (!enable_i) begin
            state_next = S_READY;
         end
         default:  state_next = S_MEMCHK;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= S_MEMCHK;
         ms_cnt_reg <= 8'h00;
      end else begin
         state_reg  <= state_next;
         ms_cnt_reg <= (enter_mc || enter_dl || state_next != state_reg) ? 8'h00 :
                       (ms_tick ? ms_cnt_reg + 8'h01 : ms_cnt_reg); // R25
      end
   end

   // ------------------------------------------------------------------------
   // Configuration loading
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         delay_ms_reg <= `CSSP_SS_OPEN_MS;
         ramp_ms_reg  <= `CSSP_SS_OPEN_MS;
         good_hi_reg  <= `CSSP_GOOD_HI_PCT;
         good_lo_reg  <= `CSSP_GOOD_LO_PCT;
         good_dly_reg <= `CSSP_GOOD_DELAY_MS;
         precise_reg  <= 1'b0;
      end else if (state_reg == S_MEMCHK && init_done && nvm_user_valid_i) begin
         delay_ms_reg <= nvm_delay_ms_i; // R01
         ramp_ms_reg  <= nvm_ramp_ms_i; // R01
      end else if (state_reg == S_STRAP) begin
         delay_ms_reg <= strap_delay; // R02 R13
         ramp_ms_reg  <= strap_ramp; // R02 R13
      end else if (bus_take) begin
         delay_ms_reg <= bus_delay_ms_i;
         ramp_ms_reg  <= bus_ramp_ms_i;
         good_hi_reg  <= bus_good_hi_pct_i; // R19
         good_lo_reg  <= bus_good_lo_pct_i; // R19
         good_dly_reg <= bus_good_delay_ms_i; // R20
         precise_reg  <= bus_precise_i; // R09
      end
   end

   // ------------------------------------------------------------------------
   // Ramp generator
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         ramp_level_o <= 8'h00;
         err_reg      <= 18'h00000;
      end else if (state_next == S_READY || state_next == S_MEMCHK || state_next == S_STRAP) begin
         ramp_level_o <= 8'h00;
         err_reg      <= 18'h00000;
      end else if (enter_rp) begin
         ramp_level_o <= (ramp_ms_reg == 8'h00) ? `CSSP_LEVEL_MAX : 8'h00; // R15
         err_reg      <= 18'h00000;
      end else if (state_reg == S_RAMP && ramp_level_o != `CSSP_LEVEL_MAX && us_tick) begin
         ramp_level_o <= step_w ? ramp_level_o + 8'h01 : ramp_level_o; // R06 R10
         err_reg      <= step_w ? err_sum - ramp_us : err_sum;
      end
   end

   // ------------------------------------------------------------------------
   // Power-good
   // ------------------------------------------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         good_cnt_reg        <= 8'h00;
         power_good_output_o <= 1'b0;
      end else if (!good_cond) begin
         good_cnt_reg        <= 8'h00; // R20
         power_good_output_o <= 1'b0; // R18 R24
      end else begin
         good_cnt_reg        <= (ms_tick && good_cnt_reg != 8'hFF) ? good_cnt_reg + 8'h01
                                : good_cnt_reg;
         power_good_output_o <= (good_cnt_reg >= good_dly_reg); // R20
      end
   end

   assign ready_o        = ready_w;
   assign delay_active_o = (state_reg == S_DELAY);
   assign ramp_done_o    = (state_reg == S_ON);

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n);

   a_init_no_ready: assert property ((state_reg == S_MEMCHK) |-> !ready_o) // R03
      else $error("ready during memory check");
   a_init_ignores_en: assert property ((state_reg == S_MEMCHK) && !init_done
      |=> state_reg == S_MEMCHK) // R22
      else $error("memory check left early");
   a_delay_min: assert property (enter_rp |-> ms_cnt_reg >= `CSSP_MIN_DELAY_MS) // R04
      else $error("ramp before minimum delay");
   a_delay_full: assert property (enter_rp |-> ms_cnt_reg >= delay_ms_reg) // R05
      else $error("ramp before configured delay");
   a_acomp_delay: assert property (enter_rp && autocomp_en_i
      |-> ms_cnt_reg >= `CSSP_ACOMP_DELAY_MS) // R17
      else $error("compensation delay too short");
   a_ramp_mono: assert property ((state_reg == S_RAMP) && $past(state_reg == S_RAMP)
      |-> ramp_level_o >= $past(ramp_level_o)) // R10
      else $error("ramp not monotonic");
   a_ramp_zero: assert property (enter_rp && ramp_ms_reg == 8'h00
      |=> ramp_level_o == `CSSP_LEVEL_MAX) // R15
      else $error("zero ramp not immediate");
   a_good_cause: assert property (power_good_output_o |-> $past(good_cond)) // R18
      else $error("power-good without conditions");
   a_good_disabled: assert property (!enable_i |=> !power_good_output_o) // R24
      else $error("power-good while disabled");
   a_good_delay: assert property ($rose(power_good_output_o)
      |-> $past(good_cnt_reg) >= good_dly_reg) // R20
      else $error("power-good delay short");
   a_restore_rerun: assert property (restore_w |=> state_reg == S_MEMCHK) // R23
      else $error("restore did not rerun check");
   a_strap_hold: assert property ((state_reg != S_STRAP) && !bus_take
      && !(state_reg == S_MEMCHK && init_done) |=> $stable(ramp_ms_reg)) // R13
      else $error("soft-start value changed");

   c_reach_on: cover property (state_reg == S_RAMP ##1 state_reg == S_ON);
   c_good_rise: cover property ($rose(power_good_output_o));
   c_restore: cover property (restore_w && state_reg == S_ON);
   c_zero_ramp: cover property (enter_rp && ramp_ms_reg == 8'h00);

endmodule

`default_nettype wire

// File: cssp_host.sv
// Partner model: the converter output stage seen by the host.
// Assumes the setpoint level 255 means full target voltage.
`timescale 1ns/100ps
`default_nettype none

module cssp_host (
   // Clock
   input  wire logic       clk_i,
   // Setpoint and load scaling in percent
   input  wire logic [7:0] level_i,
   input  wire logic [7:0] scale_pct_i,
   // Sensed output
   output logic      [9:0] vout_o
);
   // -------------------------------------------------------------------------
   // Output follows setpoint one cycle late
   // -------------------------------------------------------------------------
   // No sync clock is offered, so enable never precedes a stable one
   always_ff @(posedge clk_i) begin
      vout_o <= 10'((int'(level_i) * int'(scale_pct_i)) / 100);
   end
endmodule
`default_nettype wire

// File: tb.sv
// Testbench for the start-up sequencer: strap table, bus set-up, power-good.
// Assumes the design files and cssp_host.sv are compiled before it.
`timescale 1ns/100ps
`default_nettype none

module tb;
   localparam int MS = 256;
   typedef struct packed {logic [1:0] s; logic [4:0] c; logic a; int d; int r;} cssp_row_t;
   cssp_row_t rows [8] = '{'{2'h0,5'h00,1'b0,2,2}, '{2'h1,5'h00,1'b0,5,5},
      '{2'h2,5'h00,1'b0,10,10}, '{2'h3,5'h00,1'b0,5,5}, '{2'h3,5'h02,1'b0,20,5},
      '{2'h3,5'h1D,1'b0,20,20}, '{2'h3,5'h07,1'b0,10,2}, '{2'h0,5'h00,1'b1,5,2}};
   logic       clk_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       enable_i = 1'b1;
   logic       autocomp_en_i = 1'b0;
   logic [1:0] ss_strap_i = 2'h0;
   logic [4:0] ss_res_code_i = 5'h00;
   logic       bus_write_i = 1'b0;
   logic       bus_restore_i = 1'b0;
   logic       bus_precise_i = 1'b0;
   logic [7:0] bd = 8'h00, br = 8'h00, bh = 8'h0F, bl = 8'h0A, bp = 8'h01;
   logic [7:0] scale_pct = 8'h64;
   logic       fault_i = 1'b0;
   logic [9:0] vout_sense_i;
   logic       ready_o, delay_active_o, ramp_done_o, power_good_output_o;
   logic [7:0] ramp_level_o;
   int         failures = 0;
   int         n_tests = 0;
   int         cyc = 0;

   cssp_sequencer #(.CYC_PER_US(1), .US_PER_MS(MS), .INIT_MS(1)) u_cssp_sequencer (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
      .autocomp_en_i(autocomp_en_i), .nvm_user_valid_i(1'b1),
      .nvm_delay_ms_i(8'h14), .nvm_ramp_ms_i(8'h14),
      .ss_strap_i(ss_strap_i), .ss_res_code_i(ss_res_code_i),
      .bus_write_i(bus_write_i), .bus_delay_ms_i(bd), .bus_ramp_ms_i(br),
      .bus_good_hi_pct_i(bh), .bus_good_lo_pct_i(bl), .bus_good_delay_ms_i(bp),
      .bus_precise_i(bus_precise_i), .bus_restore_i(bus_restore_i),
      .vout_sense_i(vout_sense_i), .fault_i(fault_i), .ready_o(ready_o),
      .delay_active_o(delay_active_o), .ramp_done_o(ramp_done_o),
      .ramp_level_o(ramp_level_o), .power_good_output_o(power_good_output_o));

   cssp_host u_cssp_host (.clk_i(clk_i), .level_i(ramp_level_o),
      .scale_pct_i(scale_pct), .vout_o(vout_sense_i));

   // -------------------------------------------------------------------------
   // Clock and timeout
   // -------------------------------------------------------------------------
   initial begin
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 80000) begin
         failures++;
         results();
      end
   end

   // -------------------------------------------------------------------------
   // Shared tasks
   // -------------------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic do_reset();
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("rst_out", {ready_o, ramp_level_o, power_good_output_o}, 10'h000);
      rst_n_i <= 1'b1;
      repeat (MS / 2) @(negedge clk_i);
      chk("init_quiet", {ready_o, delay_active_o}, 2'b00);
   endtask

   task automatic bus_wr(input logic [7:0] d, r, h, l, p, input logic pr);
      @(posedge clk_i);
      {bd, br, bh, bl, bp, bus_precise_i} <= {d, r, h, l, p, pr};
      bus_write_i <= 1'b1;
      @(posedge clk_i);
      bus_write_i <= 1'b0;
   endtask

   task automatic run_seq(input int d, input int r, input bit ex, input int pgd);
      int n;
      logic mono;
      logic [7:0] prev;
      n = 0;
      mono = 1'b1;
      prev = 8'h00;
      while (delay_active_o !== 1'b1 && n < 40 * MS) begin
         @(negedge clk_i);
         n++;
      end
      n = 0;
      while (delay_active_o === 1'b1 && n < 40 * MS) begin
         @(negedge clk_i);
         n++;
      end
      if (ex) chk("delay_exact", n >= d * MS - 2 && n <= d * MS + 3, 1'b1);
      else chk("delay_len", n >= (d - 1) * MS && n <= d * MS + 3, 1'b1);
      n = 0;
      while (ramp_done_o !== 1'b1 && n < 40 * MS) begin
         @(negedge clk_i);
         if (ramp_level_o < prev) mono = 1'b0;
         prev = ramp_level_o;
         n++;
      end
      chk("ramp_len", n >= (r > 0 ? r * MS - MS / 2 : 0) && n <= r * MS + MS / 2 + 3, 1'b1);
      chk("ramp_mono", mono, 1'b1);
      chk("good_early", power_good_output_o, 1'b0);
      n = 0;
      while (power_good_output_o !== 1'b1 && n < 2 * MS) begin
         @(negedge clk_i);
         n++;
      end
      chk("good_delay", n >= (pgd > 0 ? (pgd - 1) * MS : 0) && n <= pgd * MS + 3, 1'b1);
   endtask

   task automatic win(input logic [7:0] s, input logic f, input logic exp);
      @(posedge clk_i);
      scale_pct <= s;
      fault_i <= f;
      repeat (4) @(negedge clk_i);
      chk("good_window", power_good_output_o, exp);
   endtask

   // -------------------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------------------
   initial begin
      foreach (rows[i]) begin
         @(posedge clk_i);
         ss_strap_i <= rows[i].s;
         ss_res_code_i <= rows[i].c;
         autocomp_en_i <= rows[i].a;
         do_reset();
         run_seq(rows[i].d, rows[i].r, 1'b0, 1);
      end
      @(posedge clk_i);
      ss_strap_i <= 2'h0;
      autocomp_en_i <= 1'b0;
      do_reset();
      bus_wr(8'h14, 8'h00, 8'h0F, 8'h0A, 8'h01, 1'b0);
      run_seq(2, 2, 1'b0, 1);
      @(posedge clk_i);
      enable_i <= 1'b0;
      repeat (2) @(negedge clk_i);
      chk("off_level", {ramp_level_o, power_good_output_o}, 9'h000);
      bus_wr(8'h00, 8'h00, 8'h0F, 8'h0A, 8'h00, 1'b1);
      @(posedge clk_i);
      enable_i <= 1'b1;
      run_seq(2, 0, 1'b1, 0);
      win(8'h82, 1'b0, 1'b0);
      win(8'h5F, 1'b0, 1'b1);
      win(8'h59, 1'b0, 1'b0);
      win(8'h64, 1'b1, 1'b0);
      win(8'h64, 1'b0, 1'b1);
      bus_wr(8'h00, 8'h00, 8'h28, 8'h14, 8'h00, 1'b1);
      win(8'h82, 1'b0, 1'b1);
      win(8'h59, 1'b0, 1'b1);
      win(8'h64, 1'b0, 1'b1);
      @(posedge clk_i);
      enable_i <= 1'b0;
      bus_wr(8'h03, 8'h01, 8'h0F, 8'h0A, 8'h01, 1'b1);
      @(posedge clk_i);
      enable_i <= 1'b1;
      run_seq(3, 1, 1'b1, 1);
      @(posedge clk_i);
      ss_strap_i <= 2'h2;
      bus_restore_i <= 1'b1;
      @(posedge clk_i);
      bus_restore_i <= 1'b0;
      @(negedge clk_i);
      chk("restore_busy", ready_o, 1'b0);
      run_seq(10, 10, 1'b0, 1);
      results();
   end
endmodule
`default_nettype wire
